// >>> common/mcsp_consts.vh
// constants for the main clock select and prescale block
`ifndef MCSP_CONSTS_VH
`define MCSP_CONSTS_VH
// register indices; byte address is four times the index
`define MCSP_IDX_CTRL_A      5'h00
`define MCSP_IDX_CTRL_B      5'h01
`define MCSP_IDX_LOCK        5'h02
`define MCSP_IDX_STATUS      5'h03
`define MCSP_IDX_FAST_CTRL   5'h10
`define MCSP_IDX_CAL_A       5'h11
`define MCSP_IDX_CAL_B       5'h12
`define MCSP_IDX_ULP_CTRL    5'h18
`define MCSP_IDX_XTAL_CTRL   5'h1C
// field positions
`define MCSP_RUN_STBY_BIT    1
`define MCSP_XTAL_EN_BIT     0
`define MCSP_ST_CHANGING     0
`define MCSP_ST_FAST         4
`define MCSP_ST_ULP          5
`define MCSP_ST_XTAL         6
`define MCSP_ST_EXT          7
`define MCSP_CAL_LOCK_BIT    7
// reset values
`define MCSP_CTRL_A_RST      2'h0
`define MCSP_CTRL_B_RST      5'h11
// source codes
`define MCSP_SRC_FAST        2'h0
`define MCSP_SRC_ULP         2'h1
`define MCSP_SRC_XTAL        2'h2
`define MCSP_SRC_EXT         2'h3
// sleep mode codes
`define MCSP_MODE_ACTIVE     2'h0
`define MCSP_MODE_IDLE       2'h1
`define MCSP_MODE_STANDBY    2'h2
`define MCSP_MODE_PDOWN      2'h3
// oscillator edges before ready
`define MCSP_EDGES_FAST      4
`define MCSP_EDGES_ULP       4
`define MCSP_EDGES_XTAL      2
`define MCSP_EDGES_EXT       2
// ulp edges per 1 kHz tick
`define MCSP_ULP_PER_TICK    32
`endif

// >>> rtl/mcsp_osc_monitor.v
// oscillator pin sampler, edge detector and readiness counter
`timescale 1ns/10ps
`default_nettype none
module mcsp_osc_monitor #(
    parameter EDGES = 4
) (
    input  wire clk,
    input  wire reset_n,
    input  wire enable,
    input  wire osc_pin,
    output reg  rise,
    output reg  stable
);
    reg       s1_reg;
    reg       s2_reg;
    reg       s3_reg;
    reg       lvl_reg;
    reg [3:0] cnt_reg;
    always @(posedge clk) begin
        if (!reset_n) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            lvl_reg <= 1'b1; // the zeroed stages clear this first, so a pin high at release still counts as an edge
            cnt_reg <= 4'h0;
            rise    <= 1'b0;
            stable  <= 1'b0;
        end else begin
            s1_reg <= osc_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            rise   <= 1'b0;
            // a change counts only once two stages agree
            if (s2_reg == s3_reg && s3_reg != lvl_reg) begin
                lvl_reg <= s3_reg;
                rise    <= s3_reg & enable;
            end
            if (!enable) begin
                cnt_reg <= 4'h0;
                stable  <= 1'b0;
            end else if (s2_reg == s3_reg && s3_reg && !lvl_reg
                         && !stable) begin
                cnt_reg <= cnt_reg + 4'h1;
                if ({28'h0, cnt_reg} == EDGES - 1)
                    stable <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mcsp_prescaler.v
// peripheral clock enable divider
`timescale 1ns/10ps
`default_nettype none
module mcsp_prescaler (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       main_tick,
    input  wire       enable,
    input  wire [3:0] code,
    output reg        per_tick
);
    reg [5:0] cnt_reg;
    reg [6:0] div;
    always @* begin
        case (code)
            4'h0: div = 7'h02;
            4'h1: div = 7'h04;
            4'h2: div = 7'h08;
            4'h3: div = 7'h10;
            4'h4: div = 7'h20;
            4'h5: div = 7'h40;
            4'h8: div = 7'h06;
            4'h9: div = 7'h0A;
            4'hA: div = 7'h0C;
            4'hB: div = 7'h18;
            4'hC: div = 7'h30;
            default: div = 7'h01;
        endcase
        if (!enable)
            div = 7'h01;
    end
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_reg  <= 6'h00;
            per_tick <= 1'b0;
        end else begin
            per_tick <= 1'b0;
            if (main_tick) begin
                if ({1'b0, cnt_reg} >= div - 7'h01) begin
                    cnt_reg  <= 6'h00;
                    per_tick <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mcsp_clock_ctrl.v
// main clock select, oscillator control and prescale, apb registers
// Operation
// - turn off any source neither requested nor held by run-in-standby
// - run-in-standby keeps oscillator running except in power-down
// - main clock always runs in active and idle modes
// - standby runs main clock only on request or run-in-standby of source
// - power-down stops main clock only after nvm operations finish
// - switch to external source completes only after enough edges
// - while waiting for edges further selections are ignored until reset; code ignores them only until the switch completes or reset
// - changing flag set during a source switch, cleared on completion
// - separate stable flags for external input and crystal
// - peripheral clock is main clock divided by 1 to 64
// - source and prescaler registers change only via timed write
// - after reset main clock is fast oscillator, divide by 6
// - internal sources start automatically on peripheral request
// - crystal serves only after software sets its enable bit
// - one status bit per oscillator, set when running and stable
// - calibration fields load from fuses during reset
// - lock fuse at 1 rejects calibration writes
// - calibration also locked when fast osc is main and lock enable set
// - calibration registers writable only via timed write
// - fast oscillator ready only after four cycles past start-up
// - ulp oscillator supplies a 1 kHz tick to rtc, watchdog, bod
// - ulp oscillator ready only after four cycles past start-up
// - source select 0 fast, 1 ulp, 2 crystal, 3 external input
// - division codes 0-5 give 2..64, codes 8-C give 6,10,12,24,48
// - prescaler disabled passes main clock undivided
// - external input counts as started two cycles after request
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_consts.vh"
module mcsp_clock_ctrl #(
    parameter ADDR_W = 8
) (
    input  wire              clk,
    input  wire              reset_n,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              protect_open,
    input  wire [1:0]        sleep_mode,
    input  wire              nvm_busy,
    input  wire [3:0]        periph_req,
    input  wire              main_req,
    input  wire [3:0]        osc_pin,
    input  wire [5:0]        fuse_center_cal,
    input  wire [3:0]        fuse_temp_cal,
    input  wire              calibration_lock_fuse,
    output reg  [3:0]        osc_enable,
    output reg  [1:0]        main_source,
    output reg               main_clk_run,
    output wire              main_tick,
    output wire              per_tick,
    output reg               slow_tick,
    output reg  [5:0]        center_freq_cal,
    output reg  [3:0]        temp_slope_cal
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam [4:0] CTRL_B_INIT = `MCSP_CTRL_B_RST;

    reg  [1:0] state_reg;
    reg  [1:0] target_reg;
    reg  [3:0] division_code;
    reg        prescaler_enable;
    reg        calibration_lock_enable;
    reg  [3:0] run_in_standby;
    reg        xtal_enable;
    reg  [4:0] slow_cnt_reg;
    wire [3:0] rise;
    wire [3:0] stable;
    wire       source_changing_flag;
    wire       ext_input_stable_flag;
    wire       crystal_stable_flag;
    wire [7:0] main_clock_status_reg;
    wire       wr;
    wire       rd_setup;
    wire [4:0] idx;
    wire       aligned;
    reg        mapped;
    wire       cal_locked;
    reg  [3:0] want;
    reg        run_next;
    reg  [7:0] rd_val;
    wire       pdown;
    integer    i;

    // oscillator monitors, one per source
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : mon
            localparam integer EDG = (g == 0) ? `MCSP_EDGES_FAST :
                                     (g == 1) ? `MCSP_EDGES_ULP :
                                     (g == 2) ? `MCSP_EDGES_XTAL :
                                                `MCSP_EDGES_EXT;
            mcsp_osc_monitor #(
                .EDGES   (EDG)
            ) u_mon (
                .clk     (clk),
                .reset_n (reset_n),
                .enable  (osc_enable[g]),
                .osc_pin (osc_pin[g]),
                .rise    (rise[g]),
                .stable  (stable[g])
            );
        end
    endgenerate

    // status flags
    assign source_changing_flag  = state_reg[1];
    assign ext_input_stable_flag = stable[3];
    assign crystal_stable_flag   = stable[2];
    assign main_clock_status_reg = {ext_input_stable_flag,
                                    crystal_stable_flag,
                                    stable[1], stable[0], 3'h0,
                                    source_changing_flag};

    // apb decode; slave never waits
    assign idx      = paddr[6:2];
    assign aligned  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:7] == 0);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign wr       = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;

    always @* begin
        case (idx)
            `MCSP_IDX_CTRL_A,
            `MCSP_IDX_CTRL_B,
            `MCSP_IDX_LOCK,
            `MCSP_IDX_STATUS,
            `MCSP_IDX_FAST_CTRL,
            `MCSP_IDX_CAL_A,
            `MCSP_IDX_CAL_B,
            `MCSP_IDX_ULP_CTRL,
            `MCSP_IDX_XTAL_CTRL: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // read mux; data captured in setup phase
    always @* begin
        case (idx)
            `MCSP_IDX_CTRL_A:    rd_val = {6'h00, target_reg};
            `MCSP_IDX_CTRL_B:    rd_val = {3'h0, division_code,
                                           prescaler_enable};
            `MCSP_IDX_LOCK:      rd_val = {7'h00, calibration_lock_enable};
            `MCSP_IDX_STATUS:    rd_val = main_clock_status_reg;
            `MCSP_IDX_FAST_CTRL: rd_val = {6'h00, run_in_standby[0], 1'b0};
            `MCSP_IDX_CAL_A:     rd_val = {2'h0, center_freq_cal};
            `MCSP_IDX_CAL_B:     rd_val = {calibration_lock_fuse, 3'h0,
                                           temp_slope_cal};
            `MCSP_IDX_ULP_CTRL:  rd_val = {6'h00, run_in_standby[1], 1'b0};
            `MCSP_IDX_XTAL_CTRL: rd_val = {6'h00, run_in_standby[2],
                                           xtal_enable};
            default:             rd_val = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= mapped ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end

    // software registers; protected ones need the timed-write window
    always @(posedge clk) begin
        if (!reset_n) begin
            division_code           <= CTRL_B_INIT[4:1];
            prescaler_enable        <= CTRL_B_INIT[0];
            calibration_lock_enable <= 1'b0;
            run_in_standby          <= 4'h0;
            xtal_enable             <= 1'b0;
        end else if (wr && protect_open) begin
            case (idx)
                `MCSP_IDX_CTRL_B: begin
                    division_code    <= pwdata[4:1];
                    prescaler_enable <= pwdata[0];
                end
                `MCSP_IDX_LOCK:
                    calibration_lock_enable <= pwdata[0];
                `MCSP_IDX_FAST_CTRL:
                    run_in_standby[0] <= pwdata[`MCSP_RUN_STBY_BIT];
                `MCSP_IDX_ULP_CTRL:
                    run_in_standby[1] <= pwdata[`MCSP_RUN_STBY_BIT];
                `MCSP_IDX_XTAL_CTRL: begin
                    run_in_standby[2] <= pwdata[`MCSP_RUN_STBY_BIT];
                    xtal_enable       <= pwdata[`MCSP_XTAL_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // calibration: fuse values at reset, writes gated by lock
    assign cal_locked = calibration_lock_fuse |
                        (main_source == `MCSP_SRC_FAST &&
                         calibration_lock_enable);

    always @(posedge clk) begin
        if (!reset_n) begin
            // synchronous reset, so loading fuse ports here is safe
            center_freq_cal <= fuse_center_cal;
            temp_slope_cal  <= fuse_temp_cal;
        end else if (wr && protect_open && !cal_locked) begin
            if (idx == `MCSP_IDX_CAL_A)
                center_freq_cal <= pwdata[5:0];
            if (idx == `MCSP_IDX_CAL_B)
                temp_slope_cal <= pwdata[3:0];
        end
    end

    // source switch sequencer
    always @(posedge clk) begin
        if (!reset_n) begin
            state_reg   <= ST_IDLE;
            target_reg  <= `MCSP_CTRL_A_RST;
            main_source <= `MCSP_SRC_FAST;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (wr && protect_open && idx == `MCSP_IDX_CTRL_A
                        && pwdata[1:0] != main_source) begin
                        target_reg <= pwdata[1:0];
                        state_reg  <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // selection writes ignored here; a dead source
                    // leaves this state only through reset
                    if (stable[target_reg]) begin
                        main_source <= target_reg;
                        state_reg   <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // main clock gating across sleep modes
    assign pdown = (sleep_mode == `MCSP_MODE_PDOWN);

    always @* begin
        case (sleep_mode)
            `MCSP_MODE_ACTIVE,
            `MCSP_MODE_IDLE:    run_next = 1'b1;
            `MCSP_MODE_STANDBY: run_next = main_req |
                                    run_in_standby[main_source];
            default:            run_next = nvm_busy;
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n)
            main_clk_run <= 1'b1;
        else
            main_clk_run <= run_next;
    end

    // oscillator enables from requests and run-in-standby
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            want[i] = periph_req[i] |
                      (run_in_standby[i] & ~pdown);
        end
        if (main_clk_run | run_next)
            want[main_source] = 1'b1;
        // keep old source alive while the new one proves itself
        if (state_reg == ST_WAIT) begin
            want[main_source] = 1'b1;
            want[target_reg]  = 1'b1;
        end
        want[2] = want[2] & xtal_enable;
    end

    always @(posedge clk) begin
        if (!reset_n)
            osc_enable <= 4'h1;
        else
            osc_enable <= want;
    end

    assign main_tick = rise[main_source] & main_clk_run;

    mcsp_prescaler u_presc (
        .clk       (clk),
        .reset_n   (reset_n),
        .main_tick (main_tick),
        .enable    (prescaler_enable),
        .code      (division_code),
        .per_tick  (per_tick)
    );

    // 1 kHz tick from ulp edges, only once the oscillator is ready
    always @(posedge clk) begin
        if (!reset_n) begin
            slow_cnt_reg <= 5'h00;
            slow_tick    <= 1'b0;
        end else begin
            slow_tick <= 1'b0;
            if (rise[1] && stable[1]) begin
                if ({27'h0, slow_cnt_reg} == `MCSP_ULP_PER_TICK - 1) begin
                    slow_cnt_reg <= 5'h00;
                    slow_tick    <= 1'b1;
                end else begin
                    slow_cnt_reg <= slow_cnt_reg + 5'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/mcsp_clock_ctrl_sva.sv
// port assertions for the main clock select and prescale block
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_consts.vh"
module mcsp_sva (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [1:0] sleep_mode,
    input wire logic       nvm_busy,
    input wire logic [3:0] periph_req,
    input wire logic       main_req,
    input wire logic       calibration_lock_fuse,
    input wire logic [3:0] osc_enable,
    input wire logic [1:0] main_source,
    input wire logic       main_clk_run,
    input wire logic       main_tick,
    input wire logic       per_tick,
    input wire logic       slow_tick,
    input wire logic [5:0] center_freq_cal
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_pd_busy;
        sleep_mode == `MCSP_MODE_PDOWN && nvm_busy;
    endsequence
    sequence s_sby_req;
        sleep_mode == `MCSP_MODE_STANDBY && main_req;
    endsequence
    property p_rst;
        $rose(reset_n) |-> osc_enable == 4'h1 && main_source == `MCSP_SRC_FAST && main_clk_run;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_run;
        (sleep_mode == `MCSP_MODE_ACTIVE || sleep_mode == `MCSP_MODE_IDLE) |=> main_clk_run;
    endproperty
    a_run: assert property (p_run) else $error("main clock stopped while awake");
    property p_pd;
        s_pd_busy |=> main_clk_run;
    endproperty
    a_pd: assert property (p_pd) else $error("main clock stopped during nvm work");
    property p_pdoff;
        sleep_mode == `MCSP_MODE_PDOWN && !nvm_busy |=> !main_clk_run;
    endproperty
    a_pdoff: assert property (p_pdoff) else $error("main clock runs in power-down");
    property p_sby;
        s_sby_req |=> main_clk_run;
    endproperty
    a_sby: assert property (p_sby) else $error("requested clock off in standby");
    property p_req;
        periph_req[1] |-> ##[1:3] osc_enable[1];
    endproperty
    a_req: assert property (p_req) else $error("requested oscillator not started");
    property p_gate;
        main_tick |-> main_clk_run;
    endproperty
    a_gate: assert property (p_gate) else $error("main tick while gated");
    property p_per;
        per_tick |-> $past(main_tick);
    endproperty
    a_per: assert property (p_per) else $error("peripheral tick without main tick");
    property p_lock;
        calibration_lock_fuse && $past(calibration_lock_fuse) |-> $stable(center_freq_cal);
    endproperty
    a_lock: assert property (p_lock) else $error("calibration moved under fuse lock");
    property p_slow;
        slow_tick |=> !slow_tick [*8];
    endproperty
    a_slow: assert property (p_slow) else $error("slow tick too fast");
    // the running source must never lose its oscillator in active mode
    property p_src;
        sleep_mode == `MCSP_MODE_ACTIVE [*2] |-> osc_enable[main_source];
    endproperty
    a_src: assert property (p_src) else $error("main source oscillator off");
endmodule
bind mcsp_clock_ctrl mcsp_sva u_sva (
    .clk(clk), .reset_n(reset_n), .sleep_mode(sleep_mode), .nvm_busy(nvm_busy),
    .periph_req(periph_req), .main_req(main_req),
    .calibration_lock_fuse(calibration_lock_fuse), .osc_enable(osc_enable),
    .main_source(main_source), .main_clk_run(main_clk_run), .main_tick(main_tick),
    .per_tick(per_tick), .slow_tick(slow_tick), .center_freq_cal(center_freq_cal)
);
`default_nettype wire

// >>> testbench/mcsp_osc_model.sv
// behavioural oscillators feeding the clock controller pins
`timescale 1ns/10ps
`default_nettype none
module mcsp_osc_model (
    input  wire logic       clk,
    input  wire logic [3:0] osc_enable,
    output var  logic [3:0] osc_pin
);
    // half periods in clk cycles, unlike each other so each oscillator runs at its own rate
    int         half [4] = '{2, 5, 7, 3};
    logic [3:0] cnt  [4] = '{default: 4'h0};
    initial osc_pin = 4'h0;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!osc_enable[i]) begin
                cnt[i] <= 4'h0;
            end else if (cnt[i] == half[i] - 1) begin
                cnt[i] <= 4'h0;
                osc_pin[i] <= ~osc_pin[i];
            end else begin
                cnt[i] <= cnt[i] + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_main_clock_select_and_prescale.sv
// self-checking bench for the main clock select and prescale block
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_consts.vh"
module tb_main_clock_select_and_prescale;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        protect_open = 1'b0;
    logic [1:0]  sleep_mode = 2'h0;
    logic        nvm_busy = 1'b0;
    logic [3:0]  periph_req = 4'h0;
    logic        main_req = 1'b0;
    logic        lock_fuse = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, main_clk_run, main_tick, per_tick, slow_tick;
    wire  [3:0]  osc_enable, osc_pin, temp_cal;
    wire  [1:0]  main_source;
    wire  [5:0]  center_cal;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n;
    logic [31:0] rd;
    logic        err;
    localparam logic [5:0] FUSE_C = 6'h2D;
    localparam logic [3:0] FUSE_T = 4'h9;
    localparam logic [3:0] CODES [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9,
                                         4'hA, 4'hB, 4'hC, 4'h6, 4'hF};
    localparam int DIVS [13] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1, 1};
    always #2 clk = ~clk;
    mcsp_clock_ctrl dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .protect_open(protect_open), .sleep_mode(sleep_mode), .nvm_busy(nvm_busy),
        .periph_req(periph_req), .main_req(main_req), .osc_pin(osc_pin),
        .fuse_center_cal(FUSE_C), .fuse_temp_cal(FUSE_T), .calibration_lock_fuse(lock_fuse),
        .osc_enable(osc_enable), .main_source(main_source), .main_clk_run(main_clk_run),
        .main_tick(main_tick), .per_tick(per_tick), .slow_tick(slow_tick),
        .center_freq_cal(center_cal), .temp_slope_cal(temp_cal)
    );
    mcsp_osc_model u_osc (.clk(clk), .osc_enable(osc_enable), .osc_pin(osc_pin));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        cyc(6);
        reset_n <= 1'b1;
    endtask
    // one idle edge first, so psel is never assigned twice in one time step
    task automatic apb(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
        int t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrp(input logic [4:0] idx, input logic [31:0] wd);
        @(posedge clk);
        protect_open <= 1'b1;
        apb(1'b1, idx, wd);
        protect_open <= 1'b0;
    endtask
    task automatic wait_src(input logic [1:0] s);
        int t = 0;
        while (main_source !== s && t < 600) begin
            @(posedge clk);
            t++;
        end
        chk("main_source", {30'h0, s}, {30'h0, main_source});
    endtask
    task automatic measure(output int cnt);
        int t = 0;
        cnt = 0;
        do begin
            @(posedge clk);
            t++;
        end while (per_tick !== 1'b1 && t < 2000);
        do begin
            @(posedge clk);
            t++;
            if (main_tick === 1'b1) cnt++;
        end while (per_tick !== 1'b1 && t < 4000);
    endtask
    initial begin
        #300000;
        n_errors++;
        print_verdict();
    end
    initial begin
        do_reset();
        apb(1'b0, `MCSP_IDX_CTRL_B, 0);
        chk("ctrl_b", 32'h00000011, rd);
        apb(1'b0, `MCSP_IDX_CTRL_A, 0);
        chk("ctrl_a", 32'h0, rd);
        apb(1'b0, `MCSP_IDX_CAL_A, 0);
        chk("cal_a", {26'h0, FUSE_C}, rd);
        apb(1'b0, `MCSP_IDX_CAL_B, 0);
        chk("cal_b", {28'h0, FUSE_T}, rd);
        chk("temp_port", {28'h0, FUSE_T}, {28'h0, temp_cal});
        apb(1'b0, 5'h05, 0);
        chk("unmapped", 1, err);
        cyc(40);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("fast_ready", 1, rd[`MCSP_ST_FAST]);
        chk("ulp_idle", 0, rd[`MCSP_ST_ULP]);
        periph_req <= 4'h2;
        cyc(3);
        chk("ulp_on", 1, osc_enable[1]);
        periph_req <= 4'h0;
        cyc(3);
        chk("ulp_off", 0, osc_enable[1]);
        apb(1'b1, `MCSP_IDX_CTRL_B, 32'h3);
        apb(1'b0, `MCSP_IDX_CTRL_B, 0);
        chk("ctrl_b_unprot", 32'h00000011, rd);
        foreach (CODES[i]) begin
            wrp(`MCSP_IDX_CTRL_B, {27'h0, CODES[i], 1'b1});
            measure(n);
            chk("divide", DIVS[i], n);
        end
        wrp(`MCSP_IDX_CTRL_B, {27'h0, 4'h5, 1'b0});
        measure(n);
        chk("bypass", 1, n);
        wrp(`MCSP_IDX_LOCK, 32'h1);
        wrp(`MCSP_IDX_CAL_A, 32'h15);
        apb(1'b0, `MCSP_IDX_CAL_A, 0);
        chk("cal_lock_en", {26'h0, FUSE_C}, rd);
        wrp(`MCSP_IDX_LOCK, 32'h0);
        apb(1'b1, `MCSP_IDX_CAL_A, 32'h15);
        apb(1'b0, `MCSP_IDX_CAL_A, 0);
        chk("cal_unprot", {26'h0, FUSE_C}, rd);
        wrp(`MCSP_IDX_CAL_A, 32'h15);
        cyc(1);
        chk("cal_port", 32'h15, {26'h0, center_cal});
        lock_fuse <= 1'b1;
        wrp(`MCSP_IDX_CAL_A, 32'h2A);
        apb(1'b0, `MCSP_IDX_CAL_A, 0);
        chk("cal_fuse", 32'h15, rd);
        apb(1'b0, `MCSP_IDX_CAL_B, 0);
        chk("fuse_bit", 1, rd[`MCSP_CAL_LOCK_BIT]);
        lock_fuse <= 1'b0;
        sleep_mode <= `MCSP_MODE_STANDBY;
        cyc(3);
        chk("sby_off", 0, main_clk_run);
        main_req <= 1'b1;
        cyc(3);
        chk("sby_req", 1, main_clk_run);
        main_req <= 1'b0;
        sleep_mode <= `MCSP_MODE_ACTIVE;
        wrp(`MCSP_IDX_FAST_CTRL, 32'h2);
        sleep_mode <= `MCSP_MODE_STANDBY;
        cyc(3);
        chk("sby_hold", 1, main_clk_run);
        sleep_mode <= `MCSP_MODE_PDOWN;
        nvm_busy <= 1'b1;
        cyc(3);
        chk("pd_busy", 1, main_clk_run);
        nvm_busy <= 1'b0;
        cyc(3);
        chk("pd_off", 0, main_clk_run);
        sleep_mode <= `MCSP_MODE_IDLE;
        cyc(3);
        chk("idle_on", 1, main_clk_run);
        sleep_mode <= `MCSP_MODE_ACTIVE;
        wrp(`MCSP_IDX_FAST_CTRL, 32'h0);
        wrp(`MCSP_IDX_CTRL_A, 32'h1);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("changing", 1, rd[`MCSP_ST_CHANGING]);
        wait_src(2'h1);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("changed", 0, rd[`MCSP_ST_CHANGING]);
        chk("ulp_ready", 1, rd[`MCSP_ST_ULP]);
        n = 0;
        while (slow_tick !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("slow_tick", 1, slow_tick);
        // crystal never starts without its enable bit, so the switch hangs
        wrp(`MCSP_IDX_CTRL_A, 32'h2);
        cyc(100);
        wrp(`MCSP_IDX_CTRL_A, 32'h0);
        cyc(100);
        chk("hang_src", 1, main_source);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("hang_flag", 1, rd[`MCSP_ST_CHANGING]);
        apb(1'b0, `MCSP_IDX_CTRL_A, 0);
        chk("hang_sel", 32'h2, rd);
        do_reset();
        wrp(`MCSP_IDX_XTAL_CTRL, 32'h1);
        wrp(`MCSP_IDX_CTRL_A, 32'h2);
        wait_src(2'h2);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("xtal_ok", 1, rd[`MCSP_ST_XTAL]);
        chk("ext_none", 0, rd[`MCSP_ST_EXT]);
        wrp(`MCSP_IDX_CTRL_A, 32'h3);
        wait_src(2'h3);
        apb(1'b0, `MCSP_IDX_STATUS, 0);
        chk("ext_ok", 1, rd[`MCSP_ST_EXT]);
        chk("xtal_off", 0, osc_enable[2]);
        print_verdict();
    end
endmodule
`default_nettype wire
